// >>> src/supply_monitor_builtin_selftest_params.svh
`ifndef SUPPLY_MONITOR_BUILTIN_SELFTEST_PARAMS_SVH
`define SUPPLY_MONITOR_BUILTIN_SELFTEST_PARAMS_SVH

// Register indexes as printed; the byte address is four times the index.
`define SMB_CTRL_IDX       16'h0410
`define SMB_RES_IDX        16'h0411
`define SMB_CTRL_ADDR      16'h1040
`define SMB_RES_ADDR       16'h1044

// Control register layout.
`define SMB_LAUNCH_BIT     0
`define SMB_CRC_LSB        1
`define SMB_CRC_MSB        15
`define SMB_CRC_RST        15'h0000
`define SMB_CRC_POLY       15'h4599

// Result register layout.
`define SMB_RES_MSB        11
`define SMB_RES_RST        12'h0FF
`define SMB_AUX_HIGH_IDX   4'h8
`define SMB_AUX_LOW_IDX    4'h9

// Sequence lengths.
`define SMB_STARTUP_LAST   4'h7
`define SMB_MANUAL_LAST    4'hB

`endif

// >>> src/supply_monitor_builtin_selftest_pkg.sv
package supply_monitor_builtin_selftest_pkg;

  typedef enum logic [0:0] {
    ST_IDLE,
    ST_RUN
  } seq_state_t;

  // Request to the analog monitor test circuitry.
  typedef struct packed {
    logic       req;
    logic [3:0] sel;
  } mon_req_t;

  // Answer from the analog monitor test circuitry.
  typedef struct packed {
    logic done;
    logic fail;
  } mon_rsp_t;

endpackage : supply_monitor_builtin_selftest_pkg

// >>> src/supply_monitor_builtin_selftest.sv
// Summary of operation
// - A CRC over the sequential test results sits in control bits 15:1, read-write, reset zero.
// - Writing one to control bit 0 launches a run over all monitors, skipping the auxiliary pair when aux_enabled is low; writing zero does nothing.
// - Control bit 0 is write-only and always reads zero.
// - Result bits 15:12 are reserved and read zero.
// - A start-up run where every monitor passes leaves the result register at zero.
// - Result bits 11 and 10 report core supply low and high fails, reset zero, manual run only.
// - Result bits 9 and 8 report auxiliary supply low and high fails, reset zero, manual run only.
// - Result bits 7:0 reset to one and cover the eight start-up monitors, run in ascending order, bit n for monitor n.
// - Each result flag reads 0 for pass and 1 for fail; the result register is read-only.
`timescale 1ns/1ps
`include "supply_monitor_builtin_selftest_params.svh"
`default_nettype none

module supply_monitor_builtin_selftest
  import supply_monitor_builtin_selftest_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        aux_enabled,
  input  wire mon_rsp_t    mon_rsp,
  output mon_req_t         mon_req,
  output logic             selftest_busy
);

  seq_state_t                   state_r;
  logic                         boot_pend_r;
  logic                         manual_r;
  logic [3:0]                   idx_r;
  logic [14:0]                  selftest_crc_r;
  logic [`SMB_RES_MSB:0]        result_r;
  logic                         hit_ctrl;
  logic                         hit_res;
  logic                         wr_ctrl;
  logic                         selftest_launch;
  logic                         step_done;
  logic                         last_step;
  logic [3:0]                   idx_nxt;
  logic [14:0]                  crc_nxt;

  // Folds the monitor number and its outcome into the CRC, MSB first.
  function automatic logic [14:0] crc_fold(input logic [14:0] crc,
                                           input logic [3:0]  idx,
                                           input logic        fail);
    logic [14:0] c;
    logic [4:0]  d;
    logic        fb;
    c = crc;
    d = {idx, fail};
    for (int i = 4; i >= 0; i--) begin
      fb = c[14] ^ d[i];
      c  = {c[13:0], 1'b0};
      if (fb) begin
        c = c ^ `SMB_CRC_POLY;
      end
    end
    return c;
  endfunction : crc_fold

  // Next monitor in the fixed order; the auxiliary pair is skipped when that supply is off.
  function automatic logic [3:0] next_mon(input logic [3:0] idx,
                                          input logic       aux_on);
    logic [3:0] n;
    n = idx + 4'h1;
    if (!aux_on && n == `SMB_AUX_HIGH_IDX) begin
      n = `SMB_AUX_LOW_IDX + 4'h1;
    end
    return n;
  endfunction : next_mon

  assign hit_ctrl        = (paddr == `SMB_CTRL_ADDR);
  assign hit_res         = (paddr == `SMB_RES_ADDR);
  assign wr_ctrl         = psel && penable && pwrite && hit_ctrl;
  assign selftest_launch = wr_ctrl && pwdata[`SMB_LAUNCH_BIT];
  assign step_done       = (state_r == ST_RUN) && mon_rsp.done;
  assign last_step       = manual_r ? (idx_r == `SMB_MANUAL_LAST)
                                    : (idx_r == `SMB_STARTUP_LAST);
  assign idx_nxt         = next_mon(idx_r, aux_enabled);
  assign crc_nxt         = crc_fold(selftest_crc_r, idx_r, mon_rsp.fail);

  // Zero wait states; an unmapped address answers with an error.
  assign pready        = 1'b1;
  assign pslverr       = psel && penable && !hit_ctrl && !hit_res;
  assign selftest_busy = (state_r == ST_RUN);
  assign mon_req.req   = (state_r == ST_RUN);
  assign mon_req.sel   = idx_r;

  // The start-up run is queued by reset so it begins on the first clock after release.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      boot_pend_r <= 1'b1;
    end else if (state_r == ST_IDLE) begin
      boot_pend_r <= 1'b0;
    end
  end

  // A launch during a run is ignored; the running sequence is never restarted midway.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_r  <= ST_IDLE;
      manual_r <= 1'b0;
      idx_r    <= 4'h0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (boot_pend_r) begin
            state_r  <= ST_RUN;
            manual_r <= 1'b0;
            idx_r    <= 4'h0;
          end else if (selftest_launch) begin
            state_r  <= ST_RUN;
            manual_r <= 1'b1;
            idx_r    <= 4'h0;
          end
        end
        ST_RUN: begin
          if (mon_rsp.done) begin
            if (last_step) begin
              state_r <= ST_IDLE;
            end else begin
              idx_r <= idx_nxt;
            end
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // The CRC restarts at every run; a hardware step wins over a software write.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      selftest_crc_r <= `SMB_CRC_RST;
    end else if (step_done) begin
      selftest_crc_r <= crc_nxt;
    end else if (state_r == ST_IDLE && (boot_pend_r || selftest_launch)) begin
      selftest_crc_r <= `SMB_CRC_RST;
    end else if (wr_ctrl) begin
      selftest_crc_r <= pwdata[`SMB_CRC_MSB:`SMB_CRC_LSB];
    end
  end

  // Only the sequencer writes result flags; software writes never reach them.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      result_r <= `SMB_RES_RST;
    end else if (step_done) begin
      result_r[idx_r] <= mon_rsp.fail;
    end
  end

  // Read data is captured in the setup cycle and held through the access cycle.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      if (hit_ctrl) begin
        prdata <= {16'h0000, selftest_crc_r, 1'b0};
      end else if (hit_res) begin
        prdata <= {16'h0000, 4'h0, result_r};
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  logic seen_step_r;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      seen_step_r <= 1'b0;
    end else if (step_done) begin
      seen_step_r <= 1'b1;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  property p_launch_starts;
    (state_r == ST_IDLE) && !boot_pend_r && selftest_launch
      |=> selftest_busy && manual_r && (idx_r == 4'h0);
  endproperty
  a_launch_starts: assert property (p_launch_starts)
    else $error("Launch did not start a manual run.");

  property p_zero_write_idle;
    (state_r == ST_IDLE) && !boot_pend_r && wr_ctrl && !pwdata[0] |=> !selftest_busy;
  endproperty
  a_zero_write_idle: assert property (p_zero_write_idle)
    else $error("Writing zero to the launch bit started a run.");

  property p_launch_reads_zero;
    psel && penable && !pwrite && hit_ctrl |-> (prdata[0] == 1'b0);
  endproperty
  a_launch_reads_zero: assert property (p_launch_reads_zero)
    else $error("Launch bit read back as one.");

  property p_reserved_zero;
    psel && penable && !pwrite && hit_res |-> (prdata[31:12] == 20'h00000);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("Reserved result bits read nonzero.");

  property p_startup_scope;
    selftest_busy && !manual_r |-> (idx_r <= `SMB_STARTUP_LAST);
  endproperty
  a_startup_scope: assert property (p_startup_scope)
    else $error("Start-up run reached a manual-only monitor.");

  property p_aux_skipped;
    selftest_busy && manual_r && !aux_enabled && step_done && (idx_r == 4'h7)
      |=> (idx_r == 4'hA);
  endproperty
  a_aux_skipped: assert property (p_aux_skipped)
    else $error("Auxiliary monitors were not skipped.");

  property p_reset_fail_flags;
    !seen_step_r |-> (result_r == `SMB_RES_RST);
  endproperty
  a_reset_fail_flags: assert property (p_reset_fail_flags)
    else $error("Result flags moved before any test step.");

  property p_flag_update;
    step_done |=> (result_r[$past(idx_r)] == $past(mon_rsp.fail));
  endproperty
  a_flag_update: assert property (p_flag_update)
    else $error("Result flag did not take the monitor outcome.");

  property p_result_ro;
    psel && penable && pwrite && hit_res && !step_done |=> $stable(result_r);
  endproperty
  a_result_ro: assert property (p_result_ro)
    else $error("Software write changed the result register.");

  property p_crc_fold;
    step_done |=> (selftest_crc_r == crc_fold($past(selftest_crc_r),
                                              $past(idx_r), $past(mon_rsp.fail)));
  endproperty
  a_crc_fold: assert property (p_crc_fold)
    else $error("CRC was not folded with the step outcome.");

  property p_step_advance;
    step_done && !last_step |=> selftest_busy && (idx_r > $past(idx_r));
  endproperty
  a_step_advance: assert property (p_step_advance)
    else $error("Sequencer did not advance to a later monitor.");

  property p_run_ends;
    step_done && last_step |=> !selftest_busy ##1 (selftest_busy == $past(selftest_launch));
  endproperty
  a_run_ends: assert property (p_run_ends)
    else $error("Run did not end after its last monitor.");

  // The start-up run must leave the core and auxiliary flags as they were.
  property p_manual_flags_kept;
    selftest_busy && !manual_r |=> (result_r[11:8] == $past(result_r[11:8]));
  endproperty
  a_manual_flags_kept: assert property (p_manual_flags_kept)
    else $error("Start-up run changed a manual-only result flag.");

  property p_run_clears_crc;
    (state_r == ST_IDLE) && (boot_pend_r || selftest_launch)
      |=> (selftest_crc_r == `SMB_CRC_RST);
  endproperty
  a_run_clears_crc: assert property (p_run_clears_crc)
    else $error("Run start did not clear the CRC.");

  property p_cov_startup_end;
    step_done && last_step && !manual_r;
  endproperty
  c_startup_end: cover property (p_cov_startup_end);

  property p_cov_manual_aux;
    step_done && last_step && manual_r && aux_enabled;
  endproperty
  c_manual_aux: cover property (p_cov_manual_aux);

  property p_cov_manual_noaux;
    step_done && last_step && manual_r && !aux_enabled;
  endproperty
  c_manual_noaux: cover property (p_cov_manual_noaux);

  property p_cov_fail_seen;
    step_done && mon_rsp.fail;
  endproperty
  c_fail_seen: cover property (p_cov_fail_seen);

endmodule : supply_monitor_builtin_selftest

`default_nettype wire

// >>> dv/supply_monitor_builtin_selftest_tb_top.sv
`timescale 1ns/1ps
`include "supply_monitor_builtin_selftest_params.svh"
`default_nettype none
module supply_monitor_builtin_selftest_tb_top
  import supply_monitor_builtin_selftest_pkg::*;
;
  logic        mclk = 1'b0;
  logic        rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [15:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        aux_enabled;
  mon_rsp_t    mon_rsp;
  mon_req_t    mon_req;
  logic        selftest_busy;
  logic        answer;
  logic        fail_en;
  logic        fl;
  logic [14:0] crc_m;
  logic [11:0] res_m;
  logic [14:0] wv;
  logic [32:0] exp_q[$];
  logic [3:0]  exp_sel[$];
  int          dly;
  int          miscompares;
  int          check_count;

  supply_monitor_builtin_selftest dut (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .aux_enabled(aux_enabled), .mon_rsp(mon_rsp), .mon_req(mon_req),
    .selftest_busy(selftest_busy));

  always #20 mclk = ~mclk;

  task automatic check(input logic [32:0] seen, input logic [32:0] expv);
    check_count++;
    if (seen !== expv) begin
      miscompares++;
      $display("ERROR at %0t seen %0h expected %0h", $time, seen, expv);
    end
  endtask : check

  function automatic logic [14:0] fold(input logic [14:0] c, input logic [3:0] s,
                                       input logic f);
    logic [4:0] d;
    logic       fb;
    d = {s, f};
    for (int i = 4; i >= 0; i--) begin
      fb = c[14] ^ d[i];
      c = {c[13:0], 1'b0};
      if (fb) c = c ^ `SMB_CRC_POLY;
    end
    return c;
  endfunction : fold

  // Requests are held until pready is seen high, even though it is always high today.
  task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [15:0] a, input logic [32:0] expv);
    exp_q.push_back(expv);
    apb(1'b0, a, 32'h0);
  endtask : rd

  task automatic wait_idle(input string name);
    int n;
    n = 0;
    repeat (2) @(posedge mclk);
    while (selftest_busy !== 1'b0 && n < 600) begin
      @(posedge mclk);
      n++;
    end
    if (n >= 600) miscompares++;
    check({32'(exp_sel.size()), mon_req.req}, 33'h0);
    $display("test %0s done", name);
  endtask : wait_idle

  task automatic results();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : results

  // Read results are compared at the access edge, where the master takes them.
  always @(posedge mclk) begin
    if ((psel & penable & pready & ~pwrite) === 1'b1) begin
      if (exp_q.size() == 0) miscompares++;
      else check({pslverr, prdata}, exp_q.pop_front());
    end
  end

  // Stands in for the analog monitors: answers each step after a random delay.
  always @(posedge mclk) begin
    if (mon_rsp.done === 1'b1 || answer == 1'b0) begin
      mon_rsp <= '0;
    end else if (mon_req.req === 1'b1) begin
      if (dly != 0) begin
        dly <= dly - 1;
      end else begin
        fl = fail_en & 1'($urandom_range(1, 0));
        mon_rsp <= {1'b1, fl};
        check({29'h0, mon_req.sel}, {29'h0, exp_sel.pop_front()});
        crc_m = fold(crc_m, mon_req.sel, fl);
        res_m[mon_req.sel] = fl;
        dly <= $urandom_range(2, 0);
      end
    end
  end

  initial begin
    #(40 * 20000);
    miscompares++;
    results();
  end

  initial begin
    void'($urandom(32'h0E9ED850));
    {rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 51'h0};
    {aux_enabled, mon_rsp, answer, fail_en, dly} = {1'b1, 4'h0, 32'h0};
    crc_m = 15'h0000;
    res_m = 12'h0FF;
    for (int s = 0; s < 8; s++) exp_sel.push_back(4'(s));
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    rd(`SMB_RES_ADDR, 33'h0000000FF);
    rd(`SMB_CTRL_ADDR, 33'h0);
    answer = 1'b1;
    wait_idle("startup");
    rd(`SMB_RES_ADDR, 33'h0);
    rd(`SMB_CTRL_ADDR, {17'h0, crc_m, 1'b0});
    apb(1'b1, `SMB_CTRL_ADDR, 32'h0);
    repeat (3) @(posedge mclk);
    check({32'h0, selftest_busy}, 33'h0);
    wv = 15'($urandom);
    apb(1'b1, `SMB_CTRL_ADDR, {16'h0, wv, 1'b1 ^ 1'b1});
    rd(`SMB_CTRL_ADDR, {17'h0, wv, 1'b0});
    apb(1'b1, `SMB_RES_ADDR, 32'hFFFFFFFF);
    rd(`SMB_RES_ADDR, 33'h0);
    rd(16'h1048, {1'b1, 32'h0});
    $display("test registers done");
    fail_en = 1'b1;
    // Alternating the auxiliary supply shows bits 9:8 keeping old flags when skipped.
    for (int k = 0; k < 4; k++) begin
      aux_enabled <= (k % 2 == 0);
      for (int s = 0; s < 12; s++) if (k % 2 == 0 || s < 8 || s > 9) exp_sel.push_back(4'(s));
      crc_m = 15'h0000;
      apb(1'b1, `SMB_CTRL_ADDR, {16'h0, wv, 1'b1});
      wait_idle("manual");
      rd(`SMB_RES_ADDR, {21'h0, res_m});
      rd(`SMB_CTRL_ADDR, {17'h0, crc_m, 1'b0});
    end
    repeat (4) @(posedge mclk);
    results();
  end
endmodule : supply_monitor_builtin_selftest_tb_top
`default_nettype wire
